// File: rtl/upps_consts.vh
// Constants for the user pin pass-through and analog switch control block
`ifndef UPPS_CONSTS_VH
`define UPPS_CONSTS_VH

// Register addresses carried in the command byte
`define UPPS_ADDR_PTEN     7'h01
`define UPPS_ADDR_SWCTRL   7'h02
`define UPPS_ADDR_PINCFG1  7'h04
`define UPPS_ADDR_PINCFG2  7'h05
`define UPPS_ADDR_PINCFG3  7'h06
`define UPPS_ADDR_PINCFG4  7'h07
`define UPPS_ADDR_PWMSEL   7'h08
`define UPPS_ADDR_EDGES    7'h09

// Reset values
`define UPPS_RST_PTEN      4'h0
`define UPPS_RST_SWCTRL    6'h00
`define UPPS_RST_PINCFG    7'h00
`define UPPS_RST_PWMSEL    8'h00
`define UPPS_RST_BYTE      8'h00

// Serial frame: bit count at end of command byte and end of frame
`define UPPS_CNT_W         5
`define UPPS_CNT_CMD       5'h08
`define UPPS_CNT_END       5'h10
`define UPPS_CNT_ZERO      5'h00
`define UPPS_CNT_ONE       5'h01

// Switch control register fields
`define UPPS_SW_A          5
`define UPPS_SW_B          4
`define UPPS_SW_1TOG       3
`define UPPS_SW_1CTL       2
`define UPPS_SW_2TOG       1
`define UPPS_SW_2CTL       0

// PWM selection register fields
`define UPPS_PW_AH         7
`define UPPS_PW_AL         6
`define UPPS_PW_BH         5
`define UPPS_PW_BL         4
`define UPPS_PW_1POL       3
`define UPPS_PW_2POL       2
`define UPPS_PW_1EN        1
`define UPPS_PW_2EN        0

// Pin configuration fields: mode[6:3], supply[2], polarity[1], level[0]
`define UPPS_PC_MODE_HI    6
`define UPPS_PC_MODE_LO    3
`define UPPS_PC_SUP        2
`define UPPS_PC_POL        1
`define UPPS_PC_LL         0

// Pin modes
`define UPPS_MD_GPI        4'h0
`define UPPS_MD_GPO        4'h1
`define UPPS_MD_SWA        4'h2
`define UPPS_MD_SWB        4'h3
`define UPPS_MD_CHANGEOVER_ONE      4'h4
`define UPPS_MD_CHANGEOVER_TWO      4'h5
`define UPPS_MD_PWM        4'hB
`define UPPS_MD_SHDN       4'hC
`define UPPS_MD_ALDAY      4'hD
`define UPPS_MD_DRDY       4'hF

`endif

// File: rtl/upps_top.v
// User pin pass-through, serial register port and analog switch control
`timescale 1ns/100ps
`include "upps_consts.vh"

// Summary of operation
// - Pins set to the same input function are ORed together.
// - Pass-through starts at chip select rise after a pass-through register write.
// - Pass-through ends at once when chip select falls.
// - Outside pass-through each pin follows its mode and logic level, except pin four while its enable is set.
// - Edge flags and level readback keep working during pass-through.
// - Pin four enable drives pin four low while active, high otherwise.
// - Pin three enable routes serial clock to pin three in pass-through.
// - Pin two enable routes serial data in to pin two in pass-through.
// - Pin one enable routes pin one input to serial data out.
// - Pass-through enables reset to zero.
// - Buffer switch A closes on register bit, assigned pin or PWM.
// - Buffer switch B uses the same OR from its own sources.
// - A pin adds its asserted state only when assigned to that switch.
// - PWM adds its polarity-defined on state only when selected.
// - Changeover one takes PWM through its own polarity bit.
// - Changeover one control ORs low bit, pins, PWM; high bit picks mode.
// - Ganged mode: both contacts follow the effective control.
// - Toggle mode: closed contact at zero, contacts swap at one.
// - Changeover two behaves alike with its own bits.
// - Switch control bits reset to zero.
// - Polarity one means asserted high, zero asserted low.
// - PWM mode routes PWM to the pin; disabled PWM idles at polarity level.
module upps_top (
  input  wire       CLK,
  input  wire       SYS_RST,
  input  wire       CE,
  input  wire       CS_N,
  input  wire       SCLK,
  input  wire       DIN,
  output reg        DOUT,
  input  wire [3:0] USER_PIN_IN,
  output reg  [3:0] USER_PIN_OUT,
  output reg  [3:0] USER_PIN_OE,
  output reg  [3:0] PIN_SUPPLY_SELECT,
  input  wire       PWM_WAVE,
  input  wire       PWM_ENABLE,
  output reg        BUFFER_A_SWITCH,
  output reg        BUFFER_B_SWITCH,
  output reg        NORMALLY_OPEN_CONTACT_ONE,
  output reg        NORMALLY_CLOSED_CONTACT_ONE,
  output reg        NORMALLY_OPEN_CONTACT_TWO,
  output reg        NORMALLY_CLOSED_CONTACT_TWO,
  output reg        PASSTHRU_ACTIVE
);

  // ************************************************************
  // Synchronisers and edge detection
  // ************************************************************
  reg  [1:0]                 cs_sync;
  reg  [1:0]                 sclk_sync;
  reg  [1:0]                 din_sync;
  reg  [3:0]                 pin_meta;
  reg  [3:0]                 pin_sync;
  reg                        cs_prev;
  reg                        sclk_prev;
  reg  [3:0]                 pin_prev;
  wire                       cs_n_s;
  wire                       sclk_s;
  wire                       din_s;
  wire                       sclk_rise;
  wire                       sclk_fall;
  wire                       cs_rise;
  wire                       cs_fall;

  assign cs_n_s    = cs_sync[1];
  assign sclk_s    = sclk_sync[1];
  assign din_s     = din_sync[1];
  assign sclk_rise = sclk_s & ~sclk_prev;
  assign sclk_fall = ~sclk_s & sclk_prev;
  assign cs_rise   = cs_n_s & ~cs_prev;
  assign cs_fall   = ~cs_n_s & cs_prev;

  // Two flops on chip select, serial clock, data in and user pins, then a history flop for edges
  always @(posedge CLK) begin
    if (SYS_RST) begin
      cs_sync   <= 2'h3;
      sclk_sync <= 2'h0;
      din_sync  <= 2'h0;
      pin_meta  <= 4'h0;
      pin_sync  <= 4'h0;
      cs_prev   <= 1'b1;
      sclk_prev <= 1'b0;
      pin_prev  <= 4'h0;
    end else if (CE) begin
      cs_sync   <= {cs_sync[0], CS_N};
      sclk_sync <= {sclk_sync[0], SCLK};
      din_sync  <= {din_sync[0], DIN};
      pin_meta  <= USER_PIN_IN;
      pin_sync  <= pin_meta;
      cs_prev   <= cs_n_s;
      sclk_prev <= sclk_s;
      pin_prev  <= pin_sync;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  reg  [3:0]                 pt_en;
  reg  [5:0]                 analog_switch_control;
  reg  [6:0]                 pin_cfg [0:3];
  reg  [7:0]                 pwm_sel;
  reg  [3:0]                 rise_flag;
  reg  [3:0]                 fall_flag;

  // ************************************************************
  // Serial register port
  // ************************************************************
  reg  [`UPPS_CNT_W-1:0]     bit_cnt;
  reg  [15:0]                shift_in;
  reg  [7:0]                 shift_out;
  reg                        read_cmd;
  reg                        pt_write_done;
  reg                        pt_active;
  reg  [7:0]                 edge_snap;
  reg  [7:0]                 read_data;
  wire [15:0]                next_shift;
  wire [6:0]                 cmd_addr;
  wire                       frame_end;
  wire                       cmd_end;
  wire                       write_end;
  wire [3:0]                 rise_now;
  wire [3:0]                 fall_now;
  wire [7:0]                 edge_clear;

  assign next_shift = {shift_in[14:0], din_s};
  assign cmd_addr   = cmd_end ? next_shift[7:1] : next_shift[15:9];
  assign cmd_end    = ~cs_n_s & sclk_rise & (bit_cnt == `UPPS_CNT_CMD - `UPPS_CNT_ONE);
  assign frame_end  = ~cs_n_s & sclk_rise & (bit_cnt == `UPPS_CNT_END - `UPPS_CNT_ONE);
  assign write_end  = frame_end & ~read_cmd;
  assign rise_now   = pin_sync & ~pin_prev;
  assign fall_now   = ~pin_sync & pin_prev;
  assign edge_clear = (frame_end & read_cmd && cmd_addr == `UPPS_ADDR_EDGES) ?
                      edge_snap : `UPPS_RST_BYTE;

  // Read data selection for the addressed register, zero when unmapped
  always @* begin
    read_data = `UPPS_RST_BYTE;
    case (cmd_addr)
      `UPPS_ADDR_PTEN:    read_data = {pt_en, 4'h0};
      `UPPS_ADDR_SWCTRL:  read_data = {analog_switch_control, 2'h0};
      `UPPS_ADDR_PINCFG1: read_data = {1'b0, pin_cfg[0][6:1], pin_sync[0]};
      `UPPS_ADDR_PINCFG2: read_data = {1'b0, pin_cfg[1][6:1], pin_sync[1]};
      `UPPS_ADDR_PINCFG3: read_data = {1'b0, pin_cfg[2][6:1], pin_sync[2]};
      `UPPS_ADDR_PINCFG4: read_data = {1'b0, pin_cfg[3][6:1], pin_sync[3]};
      `UPPS_ADDR_PWMSEL:  read_data = pwm_sel;
      `UPPS_ADDR_EDGES:   read_data = {rise_flag, fall_flag};
      default:            read_data = `UPPS_RST_BYTE;
    endcase
  end

  // Shift in command and data on clock rise, shift out on clock fall
  always @(posedge CLK) begin
    if (SYS_RST) begin
      bit_cnt       <= `UPPS_CNT_ZERO;
      shift_in      <= 16'h0000;
      shift_out     <= `UPPS_RST_BYTE;
      read_cmd      <= 1'b0;
      edge_snap     <= `UPPS_RST_BYTE;
      pt_write_done <= 1'b0;
      pt_active     <= 1'b0;
    end else if (CE) begin
      if (cs_n_s) begin
        bit_cnt <= `UPPS_CNT_ZERO;
      end else if (sclk_rise && bit_cnt != `UPPS_CNT_END) begin
        bit_cnt  <= bit_cnt + `UPPS_CNT_ONE;
        shift_in <= next_shift;
      end
      if (cmd_end) begin
        read_cmd  <= next_shift[0];
        shift_out <= read_data;
        edge_snap <= {rise_flag, fall_flag};
      end else if (~cs_n_s & sclk_fall & read_cmd) begin
        shift_out <= {shift_out[6:0], 1'b0};
      end
      if (cs_fall) begin
        pt_write_done <= 1'b0;
      end else if (write_end && cmd_addr == `UPPS_ADDR_PTEN) begin
        pt_write_done <= 1'b1;
      end
      if (cs_fall) begin
        pt_active <= 1'b0;
      end else if (cs_rise & pt_write_done) begin
        pt_active <= 1'b1;
      end
    end
  end

  // Register writes at the end of a full write frame
  always @(posedge CLK) begin
    if (SYS_RST) begin
      pt_en      <= `UPPS_RST_PTEN;
      analog_switch_control    <= `UPPS_RST_SWCTRL;
      pin_cfg[0] <= `UPPS_RST_PINCFG;
      pin_cfg[1] <= `UPPS_RST_PINCFG;
      pin_cfg[2] <= `UPPS_RST_PINCFG;
      pin_cfg[3] <= `UPPS_RST_PINCFG;
      pwm_sel    <= `UPPS_RST_PWMSEL;
    end else if (CE && write_end) begin
      case (cmd_addr)
        `UPPS_ADDR_PTEN:    pt_en      <= next_shift[7:4];
        `UPPS_ADDR_SWCTRL:  analog_switch_control    <= next_shift[7:2];
        `UPPS_ADDR_PINCFG1: pin_cfg[0] <= next_shift[6:0];
        `UPPS_ADDR_PINCFG2: pin_cfg[1] <= next_shift[6:0];
        `UPPS_ADDR_PINCFG3: pin_cfg[2] <= next_shift[6:0];
        `UPPS_ADDR_PINCFG4: pin_cfg[3] <= next_shift[6:0];
        `UPPS_ADDR_PWMSEL:  pwm_sel    <= next_shift[7:0];
        default:            pwm_sel    <= pwm_sel;
      endcase
    end
  end

  // Edge flags keep running in pass-through; a new edge beats the clear
  always @(posedge CLK) begin
    if (SYS_RST) begin
      rise_flag <= 4'h0;
      fall_flag <= 4'h0;
    end else if (CE) begin
      rise_flag <= (rise_flag & ~edge_clear[7:4]) | rise_now;
      fall_flag <= (fall_flag & ~edge_clear[3:0]) | fall_now;
    end
  end

  // Serial data out: pin one in pass-through with pin one enable set, else read data
  always @(posedge CLK) begin
    if (SYS_RST) begin
      DOUT <= 1'b0;
    end else if (CE) begin
      if (pt_active & pt_en[0]) begin
        DOUT <= pin_sync[0];
      end else begin
        DOUT <= shift_out[7];
      end
    end
  end

  // ************************************************************
  // User pins
  // ************************************************************
  wire [3:0]                 pt_drive;
  wire [3:0]                 pt_value;
  wire [3:0]                 asserted;
  wire [3:0]                 to_swa;
  wire [3:0]                 to_swb;
  wire [3:0]                 to_sp1;
  wire [3:0]                 to_sp2;
  reg  [3:0]                 next_out;
  reg  [3:0]                 next_oe;

  assign pt_drive = {pt_en[3], pt_en[2] & pt_active, pt_en[1] & pt_active, 1'b0};
  assign pt_value = {~pt_active, sclk_s, din_s, 1'b0};

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : pin_gen
      wire [3:0] mode;
      wire       pol;
      assign mode = pin_cfg[g][`UPPS_PC_MODE_HI:`UPPS_PC_MODE_LO];
      assign pol  = pin_cfg[g][`UPPS_PC_POL];
      assign asserted[g] = ~(pin_sync[g] ^ pol);
      assign to_swa[g] = asserted[g] & (mode == `UPPS_MD_SWA);
      assign to_swb[g] = asserted[g] & (mode == `UPPS_MD_SWB);
      assign to_sp1[g] = asserted[g] & (mode == `UPPS_MD_CHANGEOVER_ONE);
      assign to_sp2[g] = asserted[g] & (mode == `UPPS_MD_CHANGEOVER_TWO);

      // Pin drive from pass-through or from mode and logic level
      always @* begin
        next_oe[g]  = 1'b0;
        next_out[g] = 1'b0;
        if (pt_drive[g]) begin
          next_oe[g]  = 1'b1;
          next_out[g] = pt_value[g];
        end else begin
          case (mode)
            `UPPS_MD_GPO: begin
              next_oe[g]  = 1'b1;
              next_out[g] = pin_cfg[g][`UPPS_PC_LL];
            end
            `UPPS_MD_PWM: begin
              next_oe[g]  = 1'b1;
              next_out[g] = PWM_ENABLE ? ~(PWM_WAVE ^ pol) : pol;
            end
            `UPPS_MD_SHDN, `UPPS_MD_ALDAY, `UPPS_MD_DRDY: begin
              next_oe[g]  = 1'b1;
              next_out[g] = ~pol;
            end
            default: begin
              next_oe[g]  = 1'b0;
              next_out[g] = 1'b0;
            end
          endcase
        end
      end

      // Pin output flops
      always @(posedge CLK) begin
        if (SYS_RST) begin
          USER_PIN_OUT[g]      <= 1'b0;
          USER_PIN_OE[g]       <= 1'b0;
          PIN_SUPPLY_SELECT[g] <= 1'b0;
        end else if (CE) begin
          USER_PIN_OUT[g]      <= next_out[g];
          USER_PIN_OE[g]       <= next_oe[g];
          PIN_SUPPLY_SELECT[g] <= pin_cfg[g][`UPPS_PC_SUP];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Analog switch control
  // ************************************************************
  wire                       pwm_a;
  wire                       pwm_b;
  wire                       pwm_1;
  wire                       pwm_2;
  wire                       eff_a;
  wire                       eff_b;
  wire                       eff_1;
  wire                       eff_2;

  // PWM on state per switch, zero when not selected
  assign pwm_a = (pwm_sel[`UPPS_PW_AH] & PWM_WAVE) | (pwm_sel[`UPPS_PW_AL] & ~PWM_WAVE);
  assign pwm_b = (pwm_sel[`UPPS_PW_BH] & PWM_WAVE) | (pwm_sel[`UPPS_PW_BL] & ~PWM_WAVE);
  assign pwm_1 = pwm_sel[`UPPS_PW_1EN] & ~(PWM_WAVE ^ pwm_sel[`UPPS_PW_1POL]);
  assign pwm_2 = pwm_sel[`UPPS_PW_2EN] & ~(PWM_WAVE ^ pwm_sel[`UPPS_PW_2POL]);

  // Effective controls: OR of register bit, assigned pins and PWM
  assign eff_a = analog_switch_control[`UPPS_SW_A] | (|to_swa) | pwm_a;
  assign eff_b = analog_switch_control[`UPPS_SW_B] | (|to_swb) | pwm_b;
  assign eff_1 = analog_switch_control[`UPPS_SW_1CTL] | (|to_sp1) | pwm_1;
  assign eff_2 = analog_switch_control[`UPPS_SW_2CTL] | (|to_sp2) | pwm_2;

  // Switch drive flops, one clock after the inputs
  always @(posedge CLK) begin
    if (SYS_RST) begin
      BUFFER_A_SWITCH             <= 1'b0;
      BUFFER_B_SWITCH             <= 1'b0;
      NORMALLY_OPEN_CONTACT_ONE   <= 1'b0;
      NORMALLY_CLOSED_CONTACT_ONE <= 1'b0;
      NORMALLY_OPEN_CONTACT_TWO   <= 1'b0;
      NORMALLY_CLOSED_CONTACT_TWO <= 1'b0;
      PASSTHRU_ACTIVE             <= 1'b0;
    end else if (CE) begin
      BUFFER_A_SWITCH             <= eff_a;
      BUFFER_B_SWITCH             <= eff_b;
      NORMALLY_OPEN_CONTACT_ONE   <= eff_1;
      NORMALLY_CLOSED_CONTACT_ONE <= analog_switch_control[`UPPS_SW_1TOG] ? ~eff_1 : eff_1;
      NORMALLY_OPEN_CONTACT_TWO   <= eff_2;
      NORMALLY_CLOSED_CONTACT_TWO <= analog_switch_control[`UPPS_SW_2TOG] ? ~eff_2 : eff_2;
      PASSTHRU_ACTIVE             <= pt_active;
    end
  end

endmodule

// File: tb/upps_top_chk.sv
// Port assertions for the pass-through and switch control block
`timescale 1ns/100ps
module upps_top_chk (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       CE,
  input wire logic       CS_N,
  input wire logic [3:0] USER_PIN_IN,
  input wire logic [3:0] USER_PIN_OE,
  input wire logic       PWM_WAVE,
  input wire logic       PWM_ENABLE,
  input wire logic       BUFFER_A_SWITCH,
  input wire logic       BUFFER_B_SWITCH,
  input wire logic       NORMALLY_OPEN_CONTACT_ONE,
  input wire logic       NORMALLY_CLOSED_CONTACT_ONE,
  input wire logic       NORMALLY_OPEN_CONTACT_TWO,
  input wire logic       NORMALLY_CLOSED_CONTACT_TWO,
  input wire logic       PASSTHRU_ACTIVE
);
  wire [5:0] sw  = {BUFFER_A_SWITCH, BUFFER_B_SWITCH, NORMALLY_OPEN_CONTACT_ONE,
                    NORMALLY_CLOSED_CONTACT_ONE, NORMALLY_OPEN_CONTACT_TWO,
                    NORMALLY_CLOSED_CONTACT_TWO};
  wire [6:0] src = {USER_PIN_IN, PWM_WAVE, PWM_ENABLE, CE};
  reg  [6:0] src_q;
  reg  [3:0] quiet;
  // Cycles since any switch source moved or a frame was open
  always @(posedge CLK) begin
    src_q <= src;
    if (SYS_RST || !CS_N || src != src_q) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end
  // ***************
  // Properties
  // ***************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence cs_high_run;
    CS_N [*5];
  endsequence
  sequence cs_drop;
    $fell(CS_N) ##0 PASSTHRU_ACTIVE;
  endsequence
  AST_PT_HOLD: assert property (cs_high_run ##0 PASSTHRU_ACTIVE |=> PASSTHRU_ACTIVE)
    else $error("pass-through lost while chip select high");
  AST_PT_ENTRY: assert property ($rose(PASSTHRU_ACTIVE) |-> CS_N && $past(CS_N, 3))
    else $error("pass-through entered without chip select high");
  AST_PT_EXIT: assert property (cs_drop |-> ##[1:5] !PASSTHRU_ACTIVE)
    else $error("pass-through not left after chip select fall");
  AST_PT_FALL: assert property ($fell(PASSTHRU_ACTIVE) |-> !$past(CS_N, 3))
    else $error("pass-through left without chip select fall");
  AST_SW_STABLE: assert property (quiet >= 4'h4 |-> $stable(sw))
    else $error("switch outputs moved with sources quiet");
  AST_RST_QUIET: assert property ($fell(SYS_RST) |-> sw == 6'h00 && USER_PIN_OE == 4'h0
                                  && !PASSTHRU_ACTIVE)
    else $error("outputs not idle after reset");
  AST_CO1_PAIR: assert property ($changed(NORMALLY_OPEN_CONTACT_ONE) && $past(CS_N)
                                 && $past(CS_N, 2) |-> $changed(NORMALLY_CLOSED_CONTACT_ONE))
    else $error("changeover one contacts moved apart");
  AST_CO2_PAIR: assert property ($changed(NORMALLY_OPEN_CONTACT_TWO) && $past(CS_N)
                                 && $past(CS_N, 2) |-> $changed(NORMALLY_CLOSED_CONTACT_TWO))
    else $error("changeover two contacts moved apart");
endmodule

// File: tb/upps_host.sv
// Host serial master model facing the block's serial port
`timescale 1ns/100ps
module upps_host (
  input  wire logic CLK,
  output logic      CS_N,
  output logic      SCLK,
  output logic      DIN,
  input  wire logic DOUT
);
  // Idle bus at time zero
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    DIN  = 1'b0;
  end
  // Waits n edges, then steps just off the edge
  task tick(input integer n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // One 16-bit frame, MSB first; read bits taken before each SCLK fall
  task xfer(input [6:0] a, input r, input [7:0] d, output [7:0] q);
    reg [15:0] f;
    integer    i;
    f = {a, r, d};
    q = 8'h00;
    CS_N = 1'b0;
    tick(4);
    for (i = 15; i >= 0; i = i - 1) begin
      DIN = f[i];
      tick(4);
      SCLK = 1'b1;
      tick(4);
      if (i > 0 && i < 9) q[i-1] = DOUT;
      SCLK = 1'b0;
    end
    tick(4);
    DIN  = ~DIN;
    CS_N = 1'b1;
    tick(4);
  endtask
  // Link lines driven straight while pass-through is up
  task drive(input s, input d);
    SCLK = s;
    DIN  = d;
  endtask
endmodule

// File: tb/upps_top_tb.sv
// Self-checking bench for the pass-through and switch control block
`timescale 1ns/100ps
`include "upps_consts.vh"
module upps_top_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] ext = 4'h0;
  logic       pwm = 1'b0;
  logic       pwm_en = 1'b0;
  logic       ce = 1'b1;
  wire        cs_n, sclk, din, dout, pt, ba, bb, no1, nc1, no2, nc2;
  wire  [3:0] pin_out, pin_oe, sup_sel;
  wire  [3:0] pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  wire  [7:0] sw = {2'b00, ba, bb, no1, nc1, no2, nc2};
  integer     miscompares = 0;
  integer     n_checks = 0;
  integer     i, j, k;
  reg  [31:0] seed = 32'h0000_004C;
  reg   [3:0] md [0:3];
  reg   [3:0] pol;
  reg   [3:0] sup;
  reg   [7:0] q, swr, pw;

  // Free-running system clock
  always #20 clk = ~clk;

  upps_top u_upps_top (.CLK(clk), .SYS_RST(rst), .CE(ce), .CS_N(cs_n), .SCLK(sclk),
    .DIN(din), .DOUT(dout), .USER_PIN_IN(pin_in), .USER_PIN_OUT(pin_out),
    .USER_PIN_OE(pin_oe), .PIN_SUPPLY_SELECT(sup_sel), .PWM_WAVE(pwm), .PWM_ENABLE(pwm_en),
    .BUFFER_A_SWITCH(ba), .BUFFER_B_SWITCH(bb), .NORMALLY_OPEN_CONTACT_ONE(no1),
    .NORMALLY_CLOSED_CONTACT_ONE(nc1), .NORMALLY_OPEN_CONTACT_TWO(no2),
    .NORMALLY_CLOSED_CONTACT_TWO(nc2), .PASSTHRU_ACTIVE(pt));
  upps_host u_upps_host (.CLK(clk), .CS_N(cs_n), .SCLK(sclk), .DIN(din), .DOUT(dout));

  // Xorshift source with a fixed start
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  // Expected switch outputs from the bench's copy of the settings
  function automatic [7:0] sw_exp();
    reg [3:0] as;
    reg       a, b, c1, c2;
    integer   n;
    as = ~(pin_in ^ pol);
    a  = swr[7] | (pw[7] & pwm) | (pw[6] & ~pwm);
    b  = swr[6] | (pw[5] & pwm) | (pw[4] & ~pwm);
    c1 = swr[4] | (pw[1] & ~(pwm ^ pw[3]));
    c2 = swr[2] | (pw[0] & ~(pwm ^ pw[2]));
    for (n = 0; n < 4; n = n + 1) begin
      a  = a | (as[n] & (md[n] == `UPPS_MD_SWA));
      b  = b | (as[n] & (md[n] == `UPPS_MD_SWB));
      c1 = c1 | (as[n] & (md[n] == `UPPS_MD_CHANGEOVER_ONE));
      c2 = c2 | (as[n] & (md[n] == `UPPS_MD_CHANGEOVER_TWO));
    end
    sw_exp = {2'b00, a, b, c1, c1 ^ swr[5], c2, c2 ^ swr[3]};
  endfunction
  // Compare and count
  task chk(input [7:0] g, input [7:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [6:0] a, input [7:0] d);
    u_upps_host.xfer(a, 1'b0, d, q);
  endtask
  task rd(input [6:0] a);
    u_upps_host.xfer(a, 1'b1, 8'h00, q);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    #1600000;
    miscompares = miscompares + 1;
    stop_test;
  end

  // ***************
  // Test sequence
  // ***************
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    u_upps_host.tick(4);
    chk(sw, 8'h00);
    rd(`UPPS_ADDR_PTEN);
    chk(q, 8'h00);
    rd(`UPPS_ADDR_SWCTRL);
    chk(q, 8'h00);
    rd(7'h7F);
    chk(q, 8'h00);
    $display("reset test done");
    // Random switch settings; first pass zeroes every switch setting and pin mode
    for (i = 0; i < 12; i = i + 1) begin
      k = rnd();
      swr = (i == 0) ? 8'h00 : k[7:0];
      pw = (i == 0) ? 8'h00 : k[15:8];
      wr(`UPPS_ADDR_SWCTRL, swr);
      rd(`UPPS_ADDR_SWCTRL);
      chk(q, swr & 8'hFC);
      wr(`UPPS_ADDR_PWMSEL, pw);
      for (j = 0; j < 4; j = j + 1) begin
        k = rnd();
        md[j] = (i == 0 || k % 5 == 0) ? 4'h0 : 4'(k % 5 + 1);
        pol[j] = k[8];
        sup[j] = k[9];
        wr(7'(`UPPS_ADDR_PINCFG1 + j), {1'b0, md[j], sup[j], pol[j], 1'b0});
      end
      chk({4'h0, sup_sel}, {4'h0, sup});
      for (j = 0; j < 4; j = j + 1) begin
        k = rnd();
        ext = k[3:0];
        pwm = k[4];
        pwm_en = k[5];
        u_upps_host.tick(6);
        chk(sw, sw_exp());
      end
    end
    // Clock enable low freezes the switch outputs, release lets them follow
    q = sw_exp();
    ce = 1'b0;
    ext = ~ext;
    pwm = ~pwm;
    u_upps_host.tick(6);
    chk(sw, q);
    ce = 1'b1;
    u_upps_host.tick(6);
    chk(sw, sw_exp());
    $display("switch test done");
    // Output pin modes: pin three level high, pin two PWM asserted high
    wr(`UPPS_ADDR_PINCFG1, 8'h00);
    wr(`UPPS_ADDR_PINCFG2, 8'h5A);
    wr(`UPPS_ADDR_PINCFG3, 8'h09);
    wr(`UPPS_ADDR_PINCFG4, 8'h00);
    for (j = 0; j < 4; j = j + 1) begin
      k = rnd();
      pwm = k[0];
      pwm_en = j[0];
      u_upps_host.tick(3);
      chk({4'h0, pin_oe[2:1], pin_out[2:1]}, {7'h07, pwm_en ? pwm : 1'b1});
    end
    // Pass-through with all four pin enables
    ext = 4'h0;
    rd(`UPPS_ADDR_EDGES);
    wr(`UPPS_ADDR_PTEN, 8'hF0);
    u_upps_host.tick(2);
    chk({5'h00, pt, pin_oe[3], pin_out[3]}, 8'h06);
    for (j = 0; j < 8; j = j + 1) begin
      k = rnd();
      u_upps_host.drive(k[0], k[1]);
      ext[0] = j[0];
      u_upps_host.tick(6);
      chk({5'h00, pin_out[2:1], dout}, {5'h00, k[0], k[1], ext[0]});
    end
    u_upps_host.drive(1'b0, 1'b0);
    u_upps_host.tick(2);
    rd(`UPPS_ADDR_EDGES);
    chk(q & 8'h11, 8'h11);
    u_upps_host.tick(2);
    chk({3'h0, pt, pin_oe[3], pin_out[3], pin_oe[2], pin_out[2]}, 8'h0F);
    $display("pass-through test done");
    stop_test;
  end
endmodule

bind upps_top upps_top_chk u_upps_top_chk (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .CS_N(CS_N),
  .USER_PIN_IN(USER_PIN_IN), .USER_PIN_OE(USER_PIN_OE), .PWM_WAVE(PWM_WAVE),
  .PWM_ENABLE(PWM_ENABLE), .BUFFER_A_SWITCH(BUFFER_A_SWITCH),
  .BUFFER_B_SWITCH(BUFFER_B_SWITCH), .NORMALLY_OPEN_CONTACT_ONE(NORMALLY_OPEN_CONTACT_ONE),
  .NORMALLY_CLOSED_CONTACT_ONE(NORMALLY_CLOSED_CONTACT_ONE),
  .NORMALLY_OPEN_CONTACT_TWO(NORMALLY_OPEN_CONTACT_TWO),
  .NORMALLY_CLOSED_CONTACT_TWO(NORMALLY_CLOSED_CONTACT_TWO),
  .PASSTHRU_ACTIVE(PASSTHRU_ACTIVE));
